// ==== rtl/misc_instruction_execute.sv ====
// executor for interrupt, stack, standby, serial, nop and bank instructions
//
// The implementer's own choices: register access over Avalon-MM and the register addresses.
`timescale 1ns/1ns
// Summary of operation
// - global enable set instruction sets flag
// - global enable clear instruction clears flag
// - enable instructions OR immediate into nibble
// - disable instructions clear bits, update zero
// - stack write loads from E and accumulator
// - stack read returns value to E, accumulator
// - serial write loads shifter from E, accumulator
// - serial read returns shifter to E, accumulator
// - nop takes one cycle, changes nothing
// - bank select writes program counter bits 13:12
module misc_instruction_execute
    import misc_exec_pkg::*;
#(
    parameter int SP_W = 8
) (
    input wire logic clk_i,
    input wire logic rst_i,
    // decoded instruction from the core
    input wire logic op_valid_i,
    input wire logic [3:0] op_i,
    input wire logic [3:0] imm_i,
    input wire logic [3:0] e_i,
    input wire logic [3:0] ac_i,
    output logic op_ready_o,
    output logic op_done_o,
    // register writeback to E and accumulator
    output logic wb_valid_o,
    output logic [3:0] wb_e_o,
    output logic [3:0] wb_ac_o,
    // interrupt enable state
    output logic global_irq_enable_flag_o,
    output logic [3:0] irq_enable_high_nibble_o,
    output logic [3:0] irq_enable_low_nibble_o,
    output logic result_zero_flag_o,
    output logic zero_flag_write_o,
    // stack pointer and bank bits
    output logic [SP_W-1:0] stack_ptr_o,
    output logic [1:0] pc_bank_o,
    // standby
    input wire logic wake_i,
    output logic halt_mode_o,
    output logic hold_mode_o,
    // serial pins
    input wire logic serial_in_i,
    output logic serial_out_o,
    output logic serial_busy_o,
    // avalon-mm slave
    input wire logic [3:0] address_i,
    input wire logic read_i,
    input wire logic write_i,
    input wire logic [31:0] writedata_i,
    input wire logic [3:0] byteenable_i,
    output logic [31:0] readdata_o,
    output logic waitrequest_o
);
    // stack pointer is exactly the E:accumulator pair
    if (SP_W != 2 * NIB_W) begin : g_bad_sp
        $error("misc_instruction_execute: SP_W must equal two nibbles");
    end

    // unmapped offsets and unused read fields return zero
    localparam logic [31:0] RD_ZERO = 32'h0000_0000;
    // every writable register lives in the low byte lane
    localparam logic [3:0] BE_LOW = 4'h1;

    // executor phases
    typedef enum logic {S_IDLE, S_EXEC} exec_e;

    // all state of the executor
    typedef struct packed {
        exec_e st;
        logic [3:0] op;
        logic [3:0] imm;
        logic [3:0] e;
        logic [3:0] ac;
        logic gie;
        logic [3:0] eh;
        logic [3:0] el;
        logic zf;
        logic zf_wr;
        logic [SP_W-1:0] sp;
        logic [1:0] bank;
        logic halt;
        logic hold;
        logic ready;
        logic done;
        logic wb_valid;
        logic [3:0] wb_e;
        logic [3:0] wb_ac;
        logic ser_load;
        logic ser_go;
        logic [SP_W-1:0] ser_data;
        logic run_en;
        logic wait_n;
        logic [31:0] rdata;
    } exec_s;

    exec_s s_q; // registered state
    exec_s s_d; // next state

    logic [SP_W-1:0] ser_reg; // shifter contents
    logic ser_busy; // shifter running

    // byte address match on word-aligned offsets
    function automatic logic hit(input logic [3:0] addr, input logic [3:0] off);
        return addr == off;
    endfunction

    // clear selected enable bits, immediate is a mask
    function automatic logic [3:0] clr_bits(input logic [3:0] v, input logic [3:0] m);
        return v & ~m;
    endfunction

    // shift unit shares the stack pointer width
    serial_shift_unit #(
        .W(SP_W)
    ) u_shift (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .load_i(s_q.ser_load),
        .data_i(s_q.ser_data),
        .go_i(s_q.ser_go),
        .sin_i(serial_in_i),
        .shreg_o(ser_reg),
        .sout_o(serial_out_o),
        .busy_o(ser_busy)
    );

    // next-state logic: instruction flow, standby and bus slave
    always_comb begin
        // scratch values, all given a value before any use
        logic [3:0] nib;
        logic req;
        logic acc;
        logic wake;
        nib = NIB_RST;
        req = 1'b0;
        acc = 1'b0;
        wake = 1'b0;
        s_d = s_q;
        // one-cycle pulses fall back by default
        s_d.done = 1'b0;
        s_d.zf_wr = 1'b0;
        s_d.wb_valid = 1'b0;
        s_d.ser_load = 1'b0;
        s_d.ser_go = 1'b0;

        // bus: waitrequest drops one cycle after a request appears
        req = read_i || write_i;
        acc = req && !s_q.wait_n;
        // a held request sees waitrequest low for one cycle, high the next, then low again,
        // so a request kept up past acceptance is accepted a second time
        s_d.wait_n = (req && s_q.wait_n) ? 1'b0 : 1'b1;
        // pin wake and control register wake share one path
        wake = wake_i;

        // bus read data captured while the request is held
        if (read_i && s_q.wait_n) begin
            s_d.rdata = RD_ZERO;
            if (hit(address_i, REG_STATUS)) begin
                s_d.rdata[ST_EL_LSB +: 4] = s_q.el;
                s_d.rdata[ST_EH_LSB +: 4] = s_q.eh;
                s_d.rdata[ST_GIE] = s_q.gie;
                s_d.rdata[ST_ZF] = s_q.zf;
                s_d.rdata[ST_BANK_LSB +: 2] = s_q.bank;
                s_d.rdata[ST_HALT] = s_q.halt;
                s_d.rdata[ST_HOLD] = s_q.hold;
                s_d.rdata[ST_SER_BUSY] = ser_busy;
                s_d.rdata[ST_CORE_BUSY] = (s_q.st == S_EXEC);
            end else if (hit(address_i, REG_SP)) begin
                s_d.rdata[SP_W-1:0] = s_q.sp;
            end else if (hit(address_i, REG_SHIFT)) begin
                s_d.rdata[SP_W-1:0] = ser_reg;
            end else if (hit(address_i, REG_CTRL)) begin
                s_d.rdata[CT_RUN] = s_q.run_en;
            end
        end

        // bus writes take effect on the accepting edge, low byte only
        if (write_i && acc && ((byteenable_i & BE_LOW) != 4'h0)) begin
            if (hit(address_i, REG_SP)) begin
                // the instruction path below overrides a same-cycle write
                s_d.sp = writedata_i[SP_W-1:0];
            end else if (hit(address_i, REG_CTRL)) begin
                s_d.run_en = writedata_i[CT_RUN];
                wake = wake || writedata_i[CT_WAKE];
            end
        end

        // instruction flow
        unique case (s_q.st)
            S_IDLE: begin
                if (op_valid_i && s_q.ready) begin
                    if (op_i == OP_NOP) begin
                        // single cycle, no state touched
                        s_d.done = 1'b1;
                    end else begin
                        // two-cycle group: latch operands, run next cycle
                        s_d.st = S_EXEC;
                        s_d.op = op_i;
                        s_d.imm = imm_i;
                        s_d.e = e_i;
                        s_d.ac = ac_i;
                    end
                end
            end
            S_EXEC: begin
                // second cycle: effects land on this edge
                s_d.st = S_IDLE;
                s_d.done = 1'b1;
                unique case (s_q.op)
                    OP_GIRQ_ON: begin
                        s_d.gie = 1'b1;
                    end
                    OP_GIRQ_OFF: begin
                        s_d.gie = 1'b0;
                    end
                    OP_EN_OR_HI: begin
                        s_d.eh = s_q.eh | s_q.imm;
                    end
                    OP_EN_OR_LO: begin
                        s_d.el = s_q.el | s_q.imm;
                    end
                    OP_DIS_HI: begin
                        nib = clr_bits(s_q.eh, s_q.imm);
                        s_d.eh = nib;
                        s_d.zf = (nib == NIB_RST);
                        s_d.zf_wr = 1'b1;
                    end
                    OP_DIS_LO: begin
                        nib = clr_bits(s_q.el, s_q.imm);
                        s_d.el = nib;
                        s_d.zf = (nib == NIB_RST);
                        s_d.zf_wr = 1'b1;
                    end
                    OP_SP_WRITE: begin
                        s_d.sp = {s_q.e, s_q.ac};
                    end
                    OP_SP_READ: begin
                        // E takes the upper nibble
                        s_d.wb_valid = 1'b1;
                        s_d.wb_e = s_q.sp[SP_W-1 -: NIB_W];
                        s_d.wb_ac = s_q.sp[NIB_W-1:0];
                    end
                    OP_SER_WRITE: begin
                        s_d.ser_load = 1'b1;
                        s_d.ser_data = {s_q.e, s_q.ac};
                    end
                    OP_SER_READ: begin
                        // contents as they stand in the execute cycle
                        s_d.wb_valid = 1'b1;
                        s_d.wb_e = ser_reg[SP_W-1 -: NIB_W];
                        s_d.wb_ac = ser_reg[NIB_W-1:0];
                    end
                    OP_SER_GO: begin
                        s_d.ser_go = 1'b1;
                    end
                    OP_BANK: begin
                        s_d.bank = s_q.imm[1:0];
                    end
                    OP_HALT: begin
                        s_d.halt = 1'b1;
                    end
                    OP_HOLD: begin
                        s_d.hold = 1'b1;
                    end
                    default: begin
                        // unknown codes finish with no effect
                        s_d.done = 1'b1;
                    end
                endcase
            end
        endcase

        // leaving standby; entry in the same cycle has priority
        if (wake && s_q.st != S_EXEC) begin
            s_d.halt = 1'b0;
            s_d.hold = 1'b0;
        end

        // accept a new instruction only when idle, awake and enabled
        // taken from the next state so the output is a flop, not a path
        s_d.ready = (s_d.st == S_IDLE) && !s_d.halt && !s_d.hold && s_d.run_en;
    end

    // state register
    // run enable comes up set so code runs straight after reset
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s_q.st <= S_IDLE;
            s_q.op <= OP_NOP;
            s_q.imm <= NIB_RST;
            s_q.e <= NIB_RST;
            s_q.ac <= NIB_RST;
            s_q.gie <= 1'b0;
            s_q.eh <= NIB_RST;
            s_q.el <= NIB_RST;
            s_q.zf <= 1'b0;
            s_q.zf_wr <= 1'b0;
            s_q.sp <= SP_RST;
            s_q.bank <= BANK_RST;
            s_q.halt <= 1'b0;
            s_q.hold <= 1'b0;
            s_q.ready <= 1'b0;
            s_q.done <= 1'b0;
            s_q.wb_valid <= 1'b0;
            s_q.wb_e <= NIB_RST;
            s_q.wb_ac <= NIB_RST;
            s_q.ser_load <= 1'b0;
            s_q.ser_go <= 1'b0;
            s_q.ser_data <= SP_RST;
            s_q.run_en <= CTRL_RUN_RST;
            s_q.wait_n <= 1'b1;
            s_q.rdata <= RD_ZERO;
        end else begin
            s_q <= s_d;
        end
    end

    // outputs straight from the state register
    assign op_ready_o = s_q.ready;
    assign op_done_o = s_q.done;
    assign wb_valid_o = s_q.wb_valid;
    assign wb_e_o = s_q.wb_e;
    assign wb_ac_o = s_q.wb_ac;
    assign global_irq_enable_flag_o = s_q.gie;
    assign irq_enable_high_nibble_o = s_q.eh;
    assign irq_enable_low_nibble_o = s_q.el;
    assign result_zero_flag_o = s_q.zf;
    assign zero_flag_write_o = s_q.zf_wr;
    assign stack_ptr_o = s_q.sp;
    assign pc_bank_o = s_q.bank;
    assign halt_mode_o = s_q.halt;
    assign hold_mode_o = s_q.hold;
    // serial status comes from the shifter's own flops
    assign serial_busy_o = ser_busy;
    assign readdata_o = s_q.rdata;
    // waitrequest is high except in the single answering cycle
    assign waitrequest_o = s_q.wait_n;
endmodule

// ==== rtl/misc_exec_pkg.sv ====
// shared constants for the miscellaneous instruction executor
package misc_exec_pkg;
    // width of one data nibble (E and accumulator)
    localparam int NIB_W = 4;
    // operation codes presented by the decoder
    localparam logic [3:0] OP_NOP = 4'h0;
    localparam logic [3:0] OP_GIRQ_ON = 4'h1;
    localparam logic [3:0] OP_GIRQ_OFF = 4'h2;
    localparam logic [3:0] OP_EN_OR_HI = 4'h3;
    localparam logic [3:0] OP_EN_OR_LO = 4'h4;
    localparam logic [3:0] OP_DIS_HI = 4'h5;
    localparam logic [3:0] OP_DIS_LO = 4'h6;
    localparam logic [3:0] OP_SP_WRITE = 4'h7;
    localparam logic [3:0] OP_SP_READ = 4'h8;
    localparam logic [3:0] OP_HALT = 4'h9;
    localparam logic [3:0] OP_HOLD = 4'hA;
    localparam logic [3:0] OP_SER_GO = 4'hB;
    localparam logic [3:0] OP_SER_WRITE = 4'hC;
    localparam logic [3:0] OP_SER_READ = 4'hD;
    localparam logic [3:0] OP_BANK = 4'hE;
    // register byte offsets on the bus
    localparam logic [3:0] REG_STATUS = 4'h0;
    localparam logic [3:0] REG_SP = 4'h4;
    localparam logic [3:0] REG_SHIFT = 4'h8;
    localparam logic [3:0] REG_CTRL = 4'hC;
    // status field positions
    localparam int ST_EL_LSB = 0;
    localparam int ST_EH_LSB = 4;
    localparam int ST_GIE = 8;
    localparam int ST_ZF = 9;
    localparam int ST_BANK_LSB = 10;
    localparam int ST_HALT = 12;
    localparam int ST_HOLD = 13;
    localparam int ST_SER_BUSY = 14;
    localparam int ST_CORE_BUSY = 15;
    // control field positions
    localparam int CT_RUN = 0;
    localparam int CT_WAKE = 1;
    // reset values
    localparam logic CTRL_RUN_RST = 1'b1;
    localparam logic [7:0] SP_RST = 8'h00;
    localparam logic [3:0] NIB_RST = 4'h0;
    localparam logic [1:0] BANK_RST = 2'h0;
endpackage

// ==== rtl/serial_shift_unit.sv ====
// serial shift register with load, start and bit shifting
`timescale 1ns/1ns
module serial_shift_unit
    import misc_exec_pkg::*;
#(
    parameter int W = 8
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic load_i,
    input wire logic [W-1:0] data_i,
    input wire logic go_i,
    input wire logic sin_i,
    output logic [W-1:0] shreg_o,
    output logic sout_o,
    output logic busy_o
);
    // counter must hold the value W
    localparam int CW = $clog2(W + 1);
    localparam logic [CW-1:0] CNT_ZERO = '0;
    localparam logic [CW-1:0] CNT_ONE = CW'(1);
    localparam logic [CW-1:0] CNT_FULL = CW'(W);

    if (W < 2) begin : g_bad_width
        $error("serial_shift_unit: W must be at least 2");
    end

    // all state of the shifter
    typedef struct packed {
        logic [W-1:0] sr;
        logic [CW-1:0] cnt;
        logic busy;
        logic sout;
    } ser_s;

    ser_s s_q; // registered state
    ser_s s_d; // next state

    // next-state logic
    always_comb begin
        s_d = s_q;
        if (load_i) begin
            // a load aborts any shift in flight
            s_d.sr = data_i;
            s_d.busy = 1'b0;
            s_d.cnt = CNT_ZERO;
        end else if (go_i && !s_q.busy) begin
            // start: busy rises next cycle, first bit appears one cycle later
            s_d.busy = 1'b1;
            s_d.cnt = CNT_FULL;
        end else if (s_q.busy) begin
            // msb first, input fills from the bottom
            s_d.sout = s_q.sr[W-1];
            s_d.sr = {s_q.sr[W-2:0], sin_i};
            s_d.cnt = s_q.cnt - CNT_ONE;
            s_d.busy = (s_q.cnt != CNT_ONE);
        end
    end

    // state register
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign shreg_o = s_q.sr;
    assign sout_o = s_q.sout;
    assign busy_o = s_q.busy;
endmodule

// ==== testbench/misc_exec_props.sv ====
// assertion checker for the miscellaneous instruction executor
`timescale 1ns/1ns
module misc_exec_props
    import misc_exec_pkg::*;
#(
    parameter int SP_W = 8
) (
    input logic clk_i,
    input logic rst_i,
    input logic op_valid_i,
    input logic [3:0] op_i,
    input logic [3:0] imm_i,
    input logic [3:0] e_i,
    input logic [3:0] ac_i,
    input logic op_ready_o,
    input logic op_done_o,
    input logic wb_valid_o,
    input logic [3:0] wb_e_o,
    input logic [3:0] wb_ac_o,
    input logic global_irq_enable_flag_o,
    input logic [3:0] irq_enable_high_nibble_o,
    input logic [3:0] irq_enable_low_nibble_o,
    input logic result_zero_flag_o,
    input logic zero_flag_write_o,
    input logic [SP_W-1:0] stack_ptr_o,
    input logic [1:0] pc_bank_o,
    input logic halt_mode_o,
    input logic serial_busy_o
);
    // instruction accepted at this edge
    logic take;
    assign take = op_valid_i && op_ready_o;
    // single domain, so clock and reset are given once
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    // two-cycle op: ready drops, then done with the flag set
    property p_gie_on;
        take && op_i == OP_GIRQ_ON |=> !op_ready_o ##1 op_done_o && global_irq_enable_flag_o;
    endproperty
    a_gie_on: assert property (p_gie_on) else $error("global enable not set");
    property p_gie_off;
        take && op_i == OP_GIRQ_OFF |=> ##1 op_done_o && !global_irq_enable_flag_o;
    endproperty
    a_gie_off: assert property (p_gie_off) else $error("global enable not cleared");
    // value two edges back is the one before the op
    property p_or_hi;
        take && op_i == OP_EN_OR_HI |=> ##1 irq_enable_high_nibble_o ==
            ($past(irq_enable_high_nibble_o, 2) | $past(imm_i, 2));
    endproperty
    a_or_hi: assert property (p_or_hi) else $error("high nibble or wrong");
    property p_dis_lo;
        take && op_i == OP_DIS_LO |=> ##1 zero_flag_write_o && irq_enable_low_nibble_o ==
            ($past(irq_enable_low_nibble_o, 2) & ~$past(imm_i, 2))
            && result_zero_flag_o == (irq_enable_low_nibble_o == 4'h0);
    endproperty
    a_dis_lo: assert property (p_dis_lo) else $error("low nibble clear wrong");
    property p_sp_wr;
        take && op_i == OP_SP_WRITE |=> ##1 stack_ptr_o == {$past(e_i, 2), $past(ac_i, 2)};
    endproperty
    a_sp_wr: assert property (p_sp_wr) else $error("stack write wrong");
    property p_sp_rd;
        take && op_i == OP_SP_READ |=> ##1 wb_valid_o && {wb_e_o, wb_ac_o} == stack_ptr_o;
    endproperty
    a_sp_rd: assert property (p_sp_rd) else $error("stack read wrong");
    // nop finishes in one cycle and touches nothing
    property p_nop;
        take && op_i == OP_NOP |=> op_done_o && $stable(stack_ptr_o) && $stable(pc_bank_o)
            && $stable(irq_enable_low_nibble_o) && $stable(global_irq_enable_flag_o);
    endproperty
    a_nop: assert property (p_nop) else $error("nop not one clean cycle");
    property p_bank;
        take && op_i == OP_BANK |=> ##1 {2'h0, pc_bank_o} == ($past(imm_i, 2) & 4'h3);
    endproperty
    a_bank: assert property (p_bank) else $error("bank bits wrong");
    property p_halt;
        take && op_i == OP_HALT |=> ##1 halt_mode_o && !op_ready_o;
    endproperty
    a_halt: assert property (p_halt) else $error("halt not entered");
    // exact launch delay is loose, so a short window
    property p_go;
        take && op_i == OP_SER_GO && !serial_busy_o |=> ##[1:3] serial_busy_o;
    endproperty
    a_go: assert property (p_go) else $error("serial shift not started");
endmodule
bind misc_instruction_execute misc_exec_props #(.SP_W(SP_W)) props_i (
    .clk_i, .rst_i, .op_valid_i, .op_i, .imm_i, .e_i, .ac_i, .op_ready_o, .op_done_o,
    .wb_valid_o, .wb_e_o, .wb_ac_o, .global_irq_enable_flag_o, .irq_enable_high_nibble_o,
    .irq_enable_low_nibble_o, .result_zero_flag_o, .zero_flag_write_o, .stack_ptr_o,
    .pc_bank_o, .halt_mode_o, .serial_busy_o
);

// ==== testbench/misc_instruction_execute_tb_top.sv ====
// self-checking bench for the miscellaneous instruction executor
`timescale 1ns/1ns
module misc_instruction_execute_tb_top
    import misc_exec_pkg::*;
;
    // stimulus, all given a value at time zero
    logic clk_i = 1'b0, rst_i = 1'b1, op_valid_i = 1'b0, wake_i = 1'b0, serial_in_i = 1'b0;
    logic read_i = 1'b0, write_i = 1'b0;
    logic [3:0] op_i = '0, imm_i = '0, e_i = '0, ac_i = '0, address_i = '0;
    logic [3:0] byteenable_i = 4'hF;
    logic [31:0] writedata_i = '0, rd;
    // observed outputs
    logic op_ready_o, op_done_o, wb_valid_o, global_irq_enable_flag_o, result_zero_flag_o;
    logic zero_flag_write_o, halt_mode_o, hold_mode_o, serial_out_o, serial_busy_o;
    logic waitrequest_o;
    logic [3:0] wb_e_o, wb_ac_o, irq_enable_high_nibble_o, irq_enable_low_nibble_o;
    logic [7:0] stack_ptr_o;
    logic [1:0] pc_bank_o;
    logic [31:0] readdata_o;
    int n_errors = 0, comparisons = 0, lat;
    misc_instruction_execute #(.SP_W(8)) dut (
        .clk_i, .rst_i, .op_valid_i, .op_i, .imm_i, .e_i, .ac_i, .op_ready_o, .op_done_o,
        .wb_valid_o, .wb_e_o, .wb_ac_o, .global_irq_enable_flag_o, .irq_enable_high_nibble_o,
        .irq_enable_low_nibble_o, .result_zero_flag_o, .zero_flag_write_o, .stack_ptr_o,
        .pc_bank_o, .wake_i, .halt_mode_o, .hold_mode_o, .serial_in_i, .serial_out_o,
        .serial_busy_o, .address_i, .read_i, .write_i, .writedata_i, .byteenable_i,
        .readdata_o, .waitrequest_o
    );
    // 4 ns clock
    initial begin
        forever #2 clk_i = ~clk_i;
    end
    task automatic complete_run();
        $display("errors %0d comparisons %0d", n_errors, comparisons);
        if (n_errors == 0 && comparisons > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    // case equality so an unknown never matches
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic hung(input string what);
        n_errors++;
        $display("MISMATCH %s expected handshake seen none", what);
        complete_run();
    endtask
    // hold the op until taken, then count edges to done
    task automatic issue(input logic [3:0] op, imm, e, ac);
        int n;
        @(posedge clk_i);
        op_valid_i <= 1'b1;
        op_i <= op;
        imm_i <= imm;
        e_i <= e;
        ac_i <= ac;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (op_ready_o !== 1'b1 && n < 40);
        op_valid_i <= 1'b0;
        lat = 0;
        do begin
            @(posedge clk_i);
            lat++;
        end while (op_done_o !== 1'b1 && lat < 40);
        if (n >= 40 || lat >= 40) hung("op");
    endtask
    // avalon master: hold until waitrequest seen low, data taken there
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] wd);
        int n;
        @(posedge clk_i);
        address_i <= a;
        write_i <= wr;
        read_i <= !wr;
        writedata_i <= wd;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (waitrequest_o !== 1'b0 && n < 40);
        rd = readdata_o;
        read_i <= 1'b0;
        write_i <= 1'b0;
        if (n >= 40) hung("bus");
    endtask
    task automatic t_gie();
        issue(OP_GIRQ_ON, 4'h0, 4'h0, 4'h0);
        chk("gie set", 1, global_irq_enable_flag_o);
        chk("gie cycles", 2, lat);
        bus(1'b0, REG_STATUS, '0);
        chk("status gie", 1, rd[ST_GIE]);
        issue(OP_GIRQ_OFF, 4'h0, 4'h0, 4'h0);
        chk("gie clear", 0, global_irq_enable_flag_o);
    endtask
    // or twice into high, then clear bits with zero result
    task automatic t_nib();
        issue(OP_EN_OR_HI, 4'h5, 4'h0, 4'h0);
        issue(OP_EN_OR_HI, 4'hA, 4'h0, 4'h0);
        chk("or high", 4'hF, irq_enable_high_nibble_o);
        issue(OP_EN_OR_LO, 4'h9, 4'h0, 4'h0);
        chk("or low", 4'h9, irq_enable_low_nibble_o);
        chk("high kept", 4'hF, irq_enable_high_nibble_o);
        issue(OP_DIS_LO, 4'h1, 4'h0, 4'h0);
        chk("dis low", 4'h8, irq_enable_low_nibble_o);
        chk("zf clear", 0, result_zero_flag_o);
        issue(OP_DIS_HI, 4'hF, 4'h0, 4'h0);
        chk("dis high", 4'h0, irq_enable_high_nibble_o);
        chk("zf set", 1, result_zero_flag_o);
        chk("low kept", 4'h8, irq_enable_low_nibble_o);
    endtask
    task automatic t_sp();
        issue(OP_SP_WRITE, 4'h0, 4'hA, 4'h5);
        chk("sp write", 8'hA5, stack_ptr_o);
        bus(1'b0, REG_SP, '0);
        chk("sp bus", 8'hA5, rd);
        bus(1'b1, REG_SP, 32'h0000_003C);
        issue(OP_SP_READ, 4'h0, 4'h0, 4'h0);
        chk("sp read", 8'h3C, {wb_e_o, wb_ac_o});
        bus(1'b0, 4'h2, '0);
        chk("unmapped", 0, rd);
    endtask
    // load, read back, then shift in ones for eight cycles
    task automatic t_ser();
        int n;
        logic [7:0] so;
        so = '0;
        issue(OP_SER_WRITE, 4'h0, 4'h9, 4'h6);
        bus(1'b0, REG_SHIFT, '0);
        chk("shift load", 8'h96, rd);
        issue(OP_SER_READ, 4'h0, 4'h0, 4'h0);
        chk("shift read", 8'h96, {wb_e_o, wb_ac_o});
        serial_in_i <= 1'b1;
        issue(OP_SER_GO, 4'h0, 4'h0, 4'h0);
        n = 0;
        while (serial_busy_o !== 1'b1 && n < 4) begin
            @(posedge clk_i);
            n++;
        end
        chk("serial busy", 1, serial_busy_o);
        // each edge shows the bit launched on the one before, msb first
        while (serial_busy_o !== 1'b0 && n < 40) begin
            @(posedge clk_i);
            n++;
            so = {so[6:0], serial_out_o};
        end
        if (n >= 40) hung("serial");
        chk("shifted out", 8'h96, so);
        bus(1'b0, REG_SHIFT, '0);
        chk("shifted in", 8'hFF, rd);
    endtask
    task automatic t_nop();
        issue(OP_NOP, 4'hF, 4'hF, 4'hF);
        chk("nop cycles", 1, lat);
        chk("nop sp", 8'h3C, stack_ptr_o);
        chk("nop low", 4'h8, irq_enable_low_nibble_o);
    endtask
    // top immediate bit set to show the upper bits are dropped
    task automatic t_bank();
        for (int b = 0; b < 4; b++) begin
            issue(OP_BANK, {2'b10, b[1:0]}, 4'h0, 4'h0);
            chk("bank", b, pc_bank_o);
        end
    endtask
    // wake by pin, then by control register
    task automatic t_standby();
        issue(OP_HALT, 4'h0, 4'h0, 4'h0);
        chk("halt", 1, halt_mode_o);
        chk("halt ready", 0, op_ready_o);
        wake_i <= 1'b1;
        @(posedge clk_i);
        wake_i <= 1'b0;
        @(posedge clk_i);
        chk("halt woken", 0, halt_mode_o);
        issue(OP_HOLD, 4'h0, 4'h0, 4'h0);
        chk("hold", 1, hold_mode_o);
        bus(1'b1, REG_CTRL, 32'h0000_0003);
        @(posedge clk_i);
        chk("hold woken", 0, hold_mode_o);
    endtask
    initial begin
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        t_gie();
        t_nib();
        t_sp();
        t_ser();
        t_nop();
        t_bank();
        t_standby();
        complete_run();
    end
endmodule
